//--- core/synth_cfg_pkg.sv
// constants for the power, timestamp and synthesizer configuration slice
// assumes an 8-bit register port with a 7-bit register address
package synth_cfg_pkg;
  localparam logic [6:0] POWER_PROFILE_SELECT_ADDR     = 7'h37;
  localparam logic [6:0] TIMESTAMP_INPUT_CONTROL_ADDR  = 7'h3b;
  localparam logic [6:0] SYNTH_REFOUT_CONTROL_ADDR     = 7'h3c;
  localparam logic [6:0] SYNTH_FEEDBACK_DIV_ADDR       = 7'h3d;

  localparam logic [7:0] POWER_PROFILE_RESET = 8'h4b;
  localparam logic [7:0] POWER_PROFILE_LOW   = 8'h46;
  localparam logic [7:0] POWER_PROFILE_HIGH  = 8'h4b;
  localparam logic [7:0] TIMESTAMP_RESET     = 8'h00;
  localparam logic [7:0] REFOUT_RESET        = 8'h01;
  localparam logic [7:0] FEEDBACK_DIV_RESET  = 8'h00;

  localparam int TIMESTAMP_RECV_BIT = 0;
  localparam int TIMESTAMP_PECL_BIT = 1;
  localparam int REFOUT_ENABLE_BIT  = 0;
  localparam int FIRST_DIV_LSB      = 0;
  localparam int SECOND_DIV_LSB     = 2;

  // writable masks: reserved bits are stored but kept at zero
  localparam logic [7:0] TIMESTAMP_MASK    = 8'h03;
  localparam logic [7:0] REFOUT_MASK       = 8'h01;
  localparam logic [7:0] FEEDBACK_DIV_MASK = 8'h0f;

  localparam logic [2:0] FIRST_DIV_BY5 = 3'h4;
  localparam logic [2:0] FIRST_DIV_BY4 = 3'h3;
  localparam logic [2:0] FIRST_DIV_BY3 = 3'h2;
  localparam logic [1:0] SECOND_DIV_BY1 = 2'h0;
  localparam logic [1:0] SECOND_DIV_BY2 = 2'h1;
  localparam logic [1:0] SECOND_DIV_BY4 = 2'h3;
endpackage

//--- core/first_feedback_divider.sv
// first feedback divider: enable pulse every 5, 4 or 3 input pulses
// assumes the input enable is a one-cycle pulse on clock
`timescale 1ns/1ps
`default_nettype none
module first_feedback_divider (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // control
  input  wire logic       run,
  input  wire logic [1:0] code,
  input  wire logic       inPulse,
  // output
  output var  logic       outPulse
);
  logic [2:0] count_q, count_d;
  logic [2:0] last;
  logic       out_d;

  always_comb begin
    unique case (code)
      2'h0:    last = synth_cfg_pkg::FIRST_DIV_BY5;
      2'h1:    last = synth_cfg_pkg::FIRST_DIV_BY4;
      2'h2:    last = synth_cfg_pkg::FIRST_DIV_BY3;
      default: last = synth_cfg_pkg::FIRST_DIV_BY5; // reserved code held at divide-by-5
    endcase
    count_d = count_q;
    out_d   = 1'b0;
    if (!run) begin
      count_d = 3'h0;
    end else if (inPulse) begin
      if (count_q >= last) begin
        count_d = 3'h0;
        out_d   = 1'b1;
      end else begin
        count_d = count_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_q  <= 3'h0;
      outPulse <= 1'b0;
    end else begin
      count_q  <= count_d;
      outPulse <= out_d;
    end
  end
endmodule
`default_nettype wire

//--- core/second_feedback_divider.sv
// second feedback divider: enable pulse every 1, 2 or 4 input pulses
// assumes the input is the first divider's pulse
`timescale 1ns/1ps
`default_nettype none
module second_feedback_divider (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // control
  input  wire logic       run,
  input  wire logic [1:0] code,
  input  wire logic       inPulse,
  // output
  output var  logic       outPulse
);
  logic [1:0] count_q, count_d;
  logic [1:0] last;
  logic       out_d;

  always_comb begin
    unique case (code)
      2'h0:    last = synth_cfg_pkg::SECOND_DIV_BY1;
      2'h1:    last = synth_cfg_pkg::SECOND_DIV_BY2;
      2'h2:    last = synth_cfg_pkg::SECOND_DIV_BY4;
      default: last = synth_cfg_pkg::SECOND_DIV_BY1; // reserved code held at divide-by-1
    endcase
    count_d = count_q;
    out_d   = 1'b0;
    if (!run) begin
      count_d = 2'h0;
    end else if (inPulse) begin
      if (count_q >= last) begin
        count_d = 2'h0;
        out_d   = 1'b1;
      end else begin
        count_d = count_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_q  <= 2'h0;
      outPulse <= 1'b0;
    end else begin
      count_q  <= count_d;
      outPulse <= out_d;
    end
  end
endmodule
`default_nettype wire

//--- core/power_timestamp_pll_config_regs.sv
// register slice: power profile, timestamp receiver, reference output, feedback dividers
// assumes a synchronous 8-bit register port; vco rate arrives as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RQ1] low-power code only at or below 1 GSPS
// [RQ2] profile resets 0x4B; only 0x46, 0x4B legal
// [RQ3] profile written with its three companion registers
// [RQ4] calibrate after every profile change
// [RQ5] clear calibration and link enables first
// [RQ6] bit 0 enables timestamp receiver, reset off
// [RQ7] reference output needs enable and synthesizer on
// [RQ8] reference enable resets to one
// [RQ9] second divider bits 3:2: 1, 2, 4
// [RQ10] second divider output is sampling clock
// [RQ11] first divider bits 1:0: 5, 4, 3
// [RQ12] first divider feeds second divider
// [RQ13] synthesizer reset held while dividers change
// [RQ14] reserved bits written as zero
// [RQ15] reset restores all; reads return stored values
module power_timestamp_pll_config_regs (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // register port
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [6:0] regAddr,
  input  wire logic [7:0] regWdata,
  output var  logic [7:0] regRdata,
  output var  logic       regRvalid,
  // synthesizer status from elsewhere in the device
  input  wire logic       synthEnable,
  input  wire logic       synth_reset,
  input  wire logic       vcoPulse,
  // timestamp input path
  input  wire logic       timestamp_input,
  output var  logic       timestampSample,
  // outputs to analog and clocking
  output var  logic [7:0] power_profile_code,
  output var  logic       timestamp_receiver_enable,
  output var  logic       timestamp_pecl_mode,
  output var  logic       synth_reference_output,
  output var  logic       samplingClockPulse,
  output var  logic [1:0] firstDivCode,
  output var  logic [1:0] secondDivCode
);
  logic [7:0] profile_q, profile_d;
  logic [7:0] tstamp_q, tstamp_d;
  logic [7:0] refout_q, refout_d;
  logic [7:0] fbdiv_q, fbdiv_d;
  logic [7:0] rdata_d;
  logic       rvalid_d;
  logic       refoutDrive_d;
  logic       tsSample_d;
  logic       divRun;
  logic       firstOut;
  logic       secondOut;

  // register writes; reserved bits masked so they always read zero
  always_comb begin
    profile_d = profile_q;
    tstamp_d  = tstamp_q;
    refout_d  = refout_q;
    fbdiv_d   = fbdiv_q;
    if (regWrite) begin
      unique case (regAddr)
        synth_cfg_pkg::POWER_PROFILE_SELECT_ADDR:    profile_d = regWdata; // see [RQ2]
        synth_cfg_pkg::TIMESTAMP_INPUT_CONTROL_ADDR: tstamp_d = regWdata & synth_cfg_pkg::TIMESTAMP_MASK; // see [RQ14]
        synth_cfg_pkg::SYNTH_REFOUT_CONTROL_ADDR:    refout_d = regWdata & synth_cfg_pkg::REFOUT_MASK;
        synth_cfg_pkg::SYNTH_FEEDBACK_DIV_ADDR:      fbdiv_d = regWdata & synth_cfg_pkg::FEEDBACK_DIV_MASK;
        default: ;
      endcase
    end
  end

  // readback of stored values; unmapped addresses read zero
  always_comb begin
    rdata_d  = 8'h00;
    rvalid_d = regRead;
    if (regRead) begin
      unique case (regAddr)
        synth_cfg_pkg::POWER_PROFILE_SELECT_ADDR:    rdata_d = profile_q; // see [RQ15]
        synth_cfg_pkg::TIMESTAMP_INPUT_CONTROL_ADDR: rdata_d = tstamp_q;
        synth_cfg_pkg::SYNTH_REFOUT_CONTROL_ADDR:    rdata_d = refout_q;
        synth_cfg_pkg::SYNTH_FEEDBACK_DIV_ADDR:      rdata_d = fbdiv_q;
        default:                                     rdata_d = 8'h00;
      endcase
    end
  end

  // reference output and timestamp capture
  always_comb begin
    refoutDrive_d = refout_q[synth_cfg_pkg::REFOUT_ENABLE_BIT] & synthEnable; // see [RQ7]
    // disabled receiver reads as idle low
    tsSample_d    = tstamp_q[synth_cfg_pkg::TIMESTAMP_RECV_BIT] & timestamp_input; // see [RQ6]
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // see [RQ15]
      profile_q                 <= synth_cfg_pkg::POWER_PROFILE_RESET;
      tstamp_q                  <= synth_cfg_pkg::TIMESTAMP_RESET;
      refout_q                  <= synth_cfg_pkg::REFOUT_RESET; // see [RQ8]
      fbdiv_q                   <= synth_cfg_pkg::FEEDBACK_DIV_RESET;
      regRdata                  <= 8'h00;
      regRvalid                 <= 1'b0;
      synth_reference_output    <= 1'b0;
      timestampSample           <= 1'b0;
      power_profile_code        <= synth_cfg_pkg::POWER_PROFILE_RESET;
      timestamp_receiver_enable <= 1'b0;
      timestamp_pecl_mode       <= 1'b0;
      firstDivCode              <= 2'h0;
      secondDivCode             <= 2'h0;
      samplingClockPulse        <= 1'b0;
    end else begin
      profile_q                 <= profile_d;
      tstamp_q                  <= tstamp_d;
      refout_q                  <= refout_d;
      fbdiv_q                   <= fbdiv_d;
      regRdata                  <= rdata_d;
      regRvalid                 <= rvalid_d;
      synth_reference_output    <= refoutDrive_d;
      timestampSample           <= tsSample_d;
      power_profile_code        <= profile_q;
      timestamp_receiver_enable <= tstamp_q[synth_cfg_pkg::TIMESTAMP_RECV_BIT];
      timestamp_pecl_mode       <= tstamp_q[synth_cfg_pkg::TIMESTAMP_PECL_BIT];
      firstDivCode              <= fbdiv_q[synth_cfg_pkg::FIRST_DIV_LSB +: 2];
      secondDivCode             <= fbdiv_q[synth_cfg_pkg::SECOND_DIV_LSB +: 2];
      samplingClockPulse        <= secondOut; // see [RQ10]
    end
  end

  // dividers stopped while the synthesizer is off or held in reset;
  // software relies on that hold when it changes the codes
  assign divRun = synthEnable & ~synth_reset; // see [RQ13]

  first_feedback_divider firstDiv (
    .clock    (clock),
    .reset_n  (reset_n),
    .run      (divRun),
    .code     (fbdiv_q[synth_cfg_pkg::FIRST_DIV_LSB +: 2]), // see [RQ11]
    .inPulse  (vcoPulse),
    .outPulse (firstOut)
  );

  second_feedback_divider secondDiv (
    .clock    (clock),
    .reset_n  (reset_n),
    .run      (divRun),
    .code     (fbdiv_q[synth_cfg_pkg::SECOND_DIV_LSB +: 2]), // see [RQ9]
    .inPulse  (firstOut), // see [RQ12]
    .outPulse (secondOut)
  );

  // checks
  a_profile_reset: assert property (@(posedge clock) !reset_n |=> profile_q == 8'h4b) // see [RQ2]
    else $error("profile not reset to high performance");
  a_refout_reset: assert property (@(posedge clock) !reset_n |=> refout_q == 8'h01) // see [RQ8]
    else $error("reference enable not reset to one");
  a_tstamp_reset: assert property (@(posedge clock) !reset_n |=> tstamp_q == 8'h00) // see [RQ6]
    else $error("timestamp control not cleared");
  a_refout_gate: assert property (@(posedge clock) disable iff (!reset_n)
    synth_reference_output |-> $past(refout_q[0]) && $past(synthEnable)) // see [RQ7]
    else $error("reference output driven without enables");
  a_refout_on: assert property (@(posedge clock) disable iff (!reset_n)
    refout_q[0] && synthEnable |=> synth_reference_output) // see [RQ7]
    else $error("reference output not driven");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
    fbdiv_q[7:4] == 4'h0 && tstamp_q[7:2] == 6'h00 && refout_q[7:1] == 7'h00) // see [RQ14]
    else $error("reserved bits stored nonzero");
  a_readback: assert property (@(posedge clock) disable iff (!reset_n)
    regRead && !regWrite && regAddr == 7'h3d |=> regRdata == $past(fbdiv_q) && regRvalid) // see [RQ15]
    else $error("feedback divider readback wrong");
  a_write_store: assert property (@(posedge clock) disable iff (!reset_n)
    regWrite && regAddr == 7'h37 |=> profile_q == $past(regWdata)) // see [RQ2]
    else $error("profile write not stored");
  a_div_by1_5: assert property (@(posedge clock) disable iff (!reset_n)
    secondOut && fbdiv_q[3:0] == 4'h0 && divRun |-> !firstOut) // see [RQ12]
    else $error("divider chain order wrong");
  a_ts_gate: assert property (@(posedge clock) disable iff (!reset_n)
    timestampSample |-> $past(tstamp_q[0])) // see [RQ6]
    else $error("timestamp sampled while receiver off");

  c_low_power: cover property (@(posedge clock) regWrite && regAddr == 7'h37 && regWdata == 8'h46);
  c_refout_off: cover property (@(posedge clock) regWrite && regAddr == 7'h3c && regWdata == 8'h00);
  c_sample_pulse: cover property (@(posedge clock) samplingClockPulse);
  c_div_change: cover property (@(posedge clock) synth_reset && regWrite && regAddr == 7'h3d);
endmodule
`default_nettype wire

//--- bench/power_timestamp_pll_config_regs_test.sv
// self-checking bench for the power, timestamp and synthesizer configuration slice
// assumes the strobe register port and 50 MHz clock described for the design
`timescale 1ns/1ps
`default_nettype none
module power_timestamp_pll_config_regs_test;
  logic       clock;
  logic       reset_n;
  logic       regWrite;
  logic       regRead;
  logic [6:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       regRvalid;
  logic       synthEnable;
  logic       synth_reset;
  logic       vcoPulse;
  logic       timestamp_input;
  logic       timestampSample;
  logic [7:0] power_profile_code;
  logic       timestamp_receiver_enable;
  logic       timestamp_pecl_mode;
  logic       synth_reference_output;
  logic       samplingClockPulse;
  logic [1:0] firstDivCode;
  logic [1:0] secondDivCode;
  int         n_errors;
  int         total_checks;
  int         pulses;
  logic [6:0] addrs [4];
  logic [7:0] resets [4];
  logic [7:0] masks [4];
  logic [7:0] shadow [4];

  power_timestamp_pll_config_regs u_power_timestamp_pll_config_regs (
    .clock, .reset_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regRvalid,
    .synthEnable, .synth_reset, .vcoPulse, .timestamp_input, .timestampSample,
    .power_profile_code, .timestamp_receiver_enable, .timestamp_pecl_mode,
    .synth_reference_output, .samplingClockPulse, .firstDivCode, .secondDivCode
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // inputs change at the falling edge, so the rising edge sees them settled
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    int k;
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    k = 0;
    while (regRvalid !== 1'b1 && k < 4) begin
      @(negedge clock);
      k++;
    end
    chk({7'h00, regRvalid}, 8'h01);
    chk(regRdata, exp);
  endtask

  task automatic read_resets;
    for (int i = 0; i < 4; i++) begin
      shadow[i] = resets[i];
      rd(addrs[i], resets[i]);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // whole run is a few thousand cycles; this is far beyond it
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  initial begin : main
    logic [7:0] d;
    int         i;
    int         per;
    reset_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWdata = 8'h00;
    synthEnable = 1'b0;
    synth_reset = 1'b1;
    vcoPulse = 1'b0;
    timestamp_input = 1'b0;
    n_errors = 0;
    total_checks = 0;
    addrs = '{synth_cfg_pkg::POWER_PROFILE_SELECT_ADDR, synth_cfg_pkg::TIMESTAMP_INPUT_CONTROL_ADDR,
              synth_cfg_pkg::SYNTH_REFOUT_CONTROL_ADDR, synth_cfg_pkg::SYNTH_FEEDBACK_DIV_ADDR};
    resets = '{8'h4b, 8'h00, 8'h01, 8'h00};
    masks = '{8'hff, 8'h03, 8'h01, 8'h0f};
    i = $urandom(32'h789fd812);
    repeat (20) @(negedge clock);
    chk(power_profile_code, 8'h4b);
    reset_n = 1'b1;
    read_resets();
    synthEnable = 1'b1;
    repeat (2) @(negedge clock);
    chk({7'h00, synth_reference_output}, 8'h01);
    // random traffic; profile only gets its two legal codes, reserved bits written as zero
    // sampling rate taken as within the low-power limit; link, calibration off
    repeat (24) begin
      i = $urandom_range(3);
      d = (i == 0) ? (($urandom_range(1) == 1) ? 8'h46 : 8'h4b) : (8'($urandom) & masks[i]);
      synth_reset = 1'b1;
      wr(addrs[i], d);
      shadow[i] = d & masks[i];
      rd(addrs[i], shadow[i]);
      chk(power_profile_code, shadow[0]);
      chk({6'h00, timestamp_pecl_mode, timestamp_receiver_enable}, shadow[1]);
      chk({4'h0, secondDivCode, firstDivCode}, shadow[3]);
    end
    rd(7'h38, 8'h00);
    wr(7'h3e, 8'hff);
    rd(7'h7f, 8'h00);
    rd(addrs[0], shadow[0]);
    for (int k = 0; k < 4; k++) begin
      wr(addrs[2], {7'h00, k[0]});
      synthEnable = k[1];
      repeat (2) @(negedge clock);
      chk({7'h00, synth_reference_output}, {7'h00, k[0] & k[1]});
      wr(addrs[1], {7'h00, k[1]});
      timestamp_input = k[0];
      repeat (2) @(negedge clock);
      chk({7'h00, timestampSample}, {7'h00, k[0] & k[1]});
    end
    synthEnable = 1'b1;
    // divider chain from cleared counters, with the synthesizer held in reset while codes change
    for (int f = 0; f < 3; f++) begin
      for (int s = 0; s < 3; s++) begin
        synth_reset = 1'b1;
        wr(addrs[3], {4'h0, 2'(s), 2'(f)});
        @(negedge clock);
        synth_reset = 1'b0;
        per = (5 - f) * (1 << s);
        pulses = 0;
        vcoPulse = 1'b1;
        repeat (240) begin
          @(negedge clock);
          pulses += int'(samplingClockPulse);
        end
        vcoPulse = 1'b0;
        repeat (4) begin
          @(negedge clock);
          pulses += int'(samplingClockPulse);
        end
        chk(8'(pulses), 8'(240 / per));
      end
    end
    // reset in mid-run after writing every register
    // a calibration would follow the profile change; none is modelled here
    wr(addrs[0], 8'h46);
    wr(addrs[1], 8'h03);
    wr(addrs[2], 8'h00);
    synth_reset = 1'b1;
    wr(addrs[3], 8'h0a);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    read_resets();
    chk(power_profile_code, 8'h4b);
    give_verdict();
  end
endmodule
`default_nettype wire
